// ---- ccw_pkg.sv ----
// package: constants, field layout and state types of the clock driver configuration word
package ccw_pkg;

  // ****************************************************************
  // word layout
  // ****************************************************************
  localparam int unsigned CFG_W      = 96;  // full serial word
  localparam int unsigned CFG_LO     = 48;  // lowest bit held by this block
  localparam int unsigned HELD_W     = 48;  // bits 95:48
  localparam int unsigned RSV_HI     = 95;
  localparam int unsigned RSV_LO     = 62;
  localparam int unsigned B_CTL_LVL  = 61;
  localparam int unsigned B_VCO_RNG  = 60;
  localparam int unsigned B_DIS_STY  = 59;
  localparam int unsigned B_REF_EDGE = 58;
  localparam int unsigned B_PLL_OFF  = 57;
  localparam int unsigned B_BANK_HI  = 56;  // bank one
  localparam int unsigned B_BANK_LO  = 52;  // bank five
  localparam int unsigned B_FBDIV_HI = 51;
  localparam int unsigned B_FBDIV_LO = 48;
  localparam int unsigned NBANK      = 5;
  localparam int unsigned FBDIV_W    = 4;
  localparam logic [47:0] CFG_RESET  = 48'h0000_0000_0000;

  // ****************************************************************
  // jtag instruction register
  // ****************************************************************
  localparam int unsigned IR_W      = 4;
  localparam logic [3:0]  IR_CONFIG = 4'h2;  // selects the configuration chain
  localparam logic [3:0]  IR_BYPASS = 4'hf;
  localparam logic [1:0]  IR_CAPT   = 2'h1;  // fixed capture pattern

  // ****************************************************************
  // i2c framing
  // ****************************************************************
  localparam logic [4:0]  I2C_BASE   = 5'h0d;  // upper address bits, arbitrary
  localparam logic [3:0]  I2C_NBYTES = 4'hc;   // 96 bits as 12 bytes
  localparam logic [3:0]  I2C_ACKBIT = 4'h8;
  localparam logic [3:0]  I2C_RELBIT = 4'h9;

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } ccw_tap_e;

  typedef enum logic [1:0] {
    I2C_IDLE, I2C_ADDR, I2C_DATA, I2C_SKIP
  } ccw_i2c_e;

endpackage

// ---- ccw_sync.sv ----
// module: two flip-flop synchroniser for a group of outside levels
`timescale 1ns/1ps
module ccw_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// ---- ccw_config_word.sv ----
// module: serially programmed configuration word, bits 95:48, over shared jtag / i2c pins
//
// Notes on behaviour
// [RULE_01] in jtag mode the serial input is sampled on each test clock rising edge
// [RULE_02] the controller drives the select pin to choose jtag or i2c use
// [RULE_03] the controller writes zero into reserved bits 95 down to 62
// [RULE_04] bit 61 one gives 2.5v control inputs, zero gives 1.8v
// [RULE_05] bit 60 zero selects the low vco range, one the high range
// [RULE_06] bit 59 mirrors the disable style pin for disabled outputs
// [RULE_07] bit 58 zero aligns to falling reference edge, one to rising
// [RULE_08] bit 57 mirrors the pll enable pin, enabling or bypassing the pll
// [RULE_09] bits 56 to 52 disable banks one to five, like the bank pins
// [RULE_10] bits 51 to 48 code the feedback divide ratio
// [RULE_11] gated disable level comes from bit 58, otherwise disabled outputs float
// [RULE_12] the controller clears bit 57 while eeprom operations run
// [RULE_13] select low gives the pins to i2c and holds jtag in reset
// [RULE_14] new settings take effect only after a complete write transaction
`timescale 1ns/1ps
module ccw_config_word
  import ccw_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  // shared serial pins
  input  wire logic                         jtag_sel_i,
  input  wire logic                         jtag_test_clock_i,
  input  wire logic                         tms_i,
  input  wire logic                         tdi_i,
  output logic                              tdo_o,
  output logic                              tdo_oe_o,
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_o,
  input  wire logic [1:0]                   i2c_addr_i,
  // control pins
  input  wire logic                         disable_style_pin_i,
  input  wire logic [ccw_pkg::NBANK-1:0]    bank_sync_output_enable_i,
  // settings
  output logic                              ctl_level_2v5_o,
  output logic                              vco_high_range_o,
  output logic                              ref_rising_edge_o,
  output logic                              pll_bypass_o,
  output logic [ccw_pkg::FBDIV_W-1:0]       fb_divide_code_o,
  output logic [ccw_pkg::NBANK-1:0]         bank_disabled_o,
  output logic                              disable_gated_o,
  output logic                              disable_stop_high_o
);

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic [1:0]        rst_sync_r;
  logic              rst_n;
  logic [NBANK+6:0]  pins_s;
  logic              sel_s, tck_s, tms_s, tdi_s, scl_s, sda_s, style_s;
  logic [1:0]        addr_s;
  logic [NBANK-1:0]  soe_s;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ccw_sync #(.W(NBANK + 7)) u_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({jtag_sel_i, jtag_test_clock_i, tms_i, tdi_i, scl_i, sda_i, disable_style_pin_i,
               bank_sync_output_enable_i}),
    .q_o     (pins_s)
  );
  assign {sel_s, tck_s, tms_s, tdi_s, scl_s, sda_s, style_s, soe_s} = pins_s;

  // address straps are static, one more synchroniser stage group
  ccw_sync #(.W(2)) u_sync_addr (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .d_i     (i2c_addr_i),
    .q_o     (addr_s)
  );

  // ****************************************************************
  // edge detection on synchronised serial clocks and data
  // ****************************************************************
  logic tck_d_r, scl_d_r, sda_d_r;
  logic tck_rise, tck_fall, scl_rise, scl_fall, i2c_start, i2c_stop;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      tck_d_r <= tck_s;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  assign tck_rise  = tck_s & ~tck_d_r & sel_s;  // [RULE_01]
  assign tck_fall  = ~tck_s & tck_d_r & sel_s;
  assign scl_rise  = scl_s & ~scl_d_r & ~sel_s;
  assign scl_fall  = ~scl_s & scl_d_r & ~sel_s;
  assign i2c_start = scl_s & scl_d_r & ~sda_s & sda_d_r & ~sel_s;
  assign i2c_stop  = scl_s & scl_d_r & sda_s & ~sda_d_r & ~sel_s;

  // ****************************************************************
  // jtag tap controller
  // ****************************************************************
  ccw_tap_e tap_r, tap_nxt;

  always_comb begin
    case (tap_r)
      TAP_RESET:  tap_nxt = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_nxt = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_nxt = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_nxt = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_nxt = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_nxt = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_nxt = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_nxt = TAP_RESET;
    endcase
  end

  // select low holds the tap in reset whatever the test clock does
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_r <= TAP_RESET;
    end else if (!sel_s) begin
      tap_r <= TAP_RESET;  // [RULE_13]
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // ****************************************************************
  // jtag instruction and data shift paths
  // ****************************************************************
  logic [IR_W-1:0]  ir_sr_r, ir_r;
  logic [CFG_W-1:0] dr_sr_r;
  logic             byp_r;
  logic             cfg_sel;
  logic             jtag_apply;
  logic [HELD_W-1:0] cfg_r;  // live word, loaded below

  assign cfg_sel    = (ir_r == IR_CONFIG);
  assign jtag_apply = tck_rise & (tap_r == TAP_UPD_DR) & cfg_sel;

  // instruction register, reset by the tap reset state
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_sr_r <= IR_BYPASS;
      ir_r    <= IR_BYPASS;
    end else if (tap_r == TAP_RESET) begin
      ir_sr_r <= IR_BYPASS;  // [RULE_13]
      ir_r    <= IR_BYPASS;
    end else if (tck_rise) begin
      case (tap_r)
        TAP_CAP_IR: ir_sr_r <= {{(IR_W-2){1'b0}}, IR_CAPT};
        TAP_SH_IR:  ir_sr_r <= {tdi_s, ir_sr_r[IR_W-1:1]};  // [RULE_01]
        TAP_UPD_IR: ir_r    <= ir_sr_r;
        default:    ir_sr_r <= ir_sr_r;
      endcase
    end
  end

  // data chain: captures the live word, shifts lsb out first
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dr_sr_r <= '0;
      byp_r   <= 1'b0;
    end else if (tck_rise) begin
      case (tap_r)
        TAP_CAP_DR: begin
          dr_sr_r <= {cfg_r, {CFG_LO{1'b0}}};
          byp_r   <= 1'b0;
        end
        TAP_SH_DR: begin
          if (cfg_sel) begin
            dr_sr_r <= {tdi_s, dr_sr_r[CFG_W-1:1]};  // [RULE_01]
          end
          byp_r <= tdi_s;
        end
        default: byp_r <= byp_r;
      endcase
    end
  end

  // tdo changes on the falling test clock edge, driven only while shifting
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (!sel_s) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= (tap_r == TAP_SH_DR) || (tap_r == TAP_SH_IR);
      if (tap_r == TAP_SH_IR) begin
        tdo_o <= ir_sr_r[0];
      end else begin
        tdo_o <= cfg_sel ? dr_sr_r[0] : byp_r;
      end
    end
  end

  // ****************************************************************
  // i2c write-only slave
  // ****************************************************************
  ccw_i2c_e         i2c_r;
  logic [3:0]       bit_cnt_r, nbytes_r;
  logic [7:0]       byte_sr_r;
  logic [CFG_W-1:0] i2c_word_r;
  logic             i2c_apply;

  assign i2c_apply = i2c_stop & (i2c_r == I2C_DATA) & (nbytes_r == I2C_NBYTES);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      i2c_r      <= I2C_IDLE;
      bit_cnt_r  <= 4'h0;
      nbytes_r   <= 4'h0;
      byte_sr_r  <= 8'h00;
      i2c_word_r <= '0;
      sda_oe_o   <= 1'b0;
    end else if (sel_s || i2c_stop) begin
      i2c_r    <= I2C_IDLE;  // [RULE_13]
      sda_oe_o <= 1'b0;
    end else if (i2c_start) begin
      i2c_r     <= I2C_ADDR;
      bit_cnt_r <= 4'h0;
      nbytes_r  <= 4'h0;
      sda_oe_o  <= 1'b0;
    end else if (i2c_r != I2C_IDLE) begin
      if (scl_rise && bit_cnt_r < I2C_ACKBIT) begin
        byte_sr_r <= {byte_sr_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && bit_cnt_r == I2C_ACKBIT) begin
        bit_cnt_r <= I2C_RELBIT;
        case (i2c_r)
          I2C_ADDR: begin
            if (byte_sr_r == {I2C_BASE, addr_s, 1'b0}) begin
              i2c_r    <= I2C_DATA;
              sda_oe_o <= 1'b1;
            end else begin
              i2c_r <= I2C_SKIP;
            end
          end
          I2C_DATA: begin
            if (nbytes_r < I2C_NBYTES) begin
              i2c_word_r <= {i2c_word_r[CFG_W-9:0], byte_sr_r};
              nbytes_r   <= nbytes_r + 4'h1;
              sda_oe_o   <= 1'b1;
            end
          end
          default: sda_oe_o <= 1'b0;
        endcase
      end else if (scl_fall && bit_cnt_r == I2C_RELBIT) begin
        bit_cnt_r <= 4'h0;
        sda_oe_o  <= 1'b0;
      end
    end
  end

  // sda only ever pulls low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ****************************************************************
  // live configuration word, loaded only at transaction end
  // ****************************************************************

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (jtag_apply) begin
      cfg_r <= dr_sr_r[CFG_W-1:CFG_LO];  // [RULE_14]
    end else if (i2c_apply) begin
      cfg_r <= i2c_word_r[CFG_W-1:CFG_LO];  // [RULE_14]
    end
  end

  assign ctl_level_2v5_o   = cfg_r[B_CTL_LVL - CFG_LO];   // [RULE_04]
  assign vco_high_range_o  = cfg_r[B_VCO_RNG - CFG_LO];   // [RULE_05]
  assign ref_rising_edge_o = cfg_r[B_REF_EDGE - CFG_LO];  // [RULE_07]
  assign pll_bypass_o      = cfg_r[B_PLL_OFF - CFG_LO];   // [RULE_08]
  assign fb_divide_code_o  = cfg_r[B_FBDIV_HI-CFG_LO:B_FBDIV_LO-CFG_LO];  // [RULE_10]

  // ****************************************************************
  // output disable state: pins or bits disable, style picks gate or float
  // ****************************************************************
  logic [NBANK-1:0] bank_bits;
  assign bank_bits = cfg_r[B_BANK_HI-CFG_LO:B_BANK_LO-CFG_LO];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank_disabled_o     <= '0;
      disable_gated_o     <= 1'b0;
      disable_stop_high_o <= 1'b1;
    end else begin
      bank_disabled_o     <= bank_bits | soe_s;  // [RULE_09]
      disable_gated_o     <= style_s | cfg_r[B_DIS_STY - CFG_LO];  // [RULE_06] [RULE_11]
      disable_stop_high_o <= ~cfg_r[B_REF_EDGE - CFG_LO];  // [RULE_11]
    end
  end

endmodule

// ---- ccw_config_word_props.sv ----
// checker: port relations of the configuration word block
`timescale 1ns/1ps
module ccw_config_word_props
  import ccw_pkg::*;
(
  // clock and reset
  input wire logic                        core_clk_i,
  input wire logic                        resetn_i,
  // serial pins
  input wire logic                        jtag_sel_i,
  input wire logic                        jtag_test_clock_i,
  input wire logic                        tms_i,
  input wire logic                        tdi_i,
  input wire logic                        tdo_o,
  input wire logic                        tdo_oe_o,
  input wire logic                        scl_i,
  input wire logic                        sda_i,
  input wire logic                        sda_o,
  input wire logic                        sda_oe_o,
  input wire logic [1:0]                  i2c_addr_i,
  // control pins
  input wire logic                        disable_style_pin_i,
  input wire logic [ccw_pkg::NBANK-1:0]   bank_sync_output_enable_i,
  // settings
  input wire logic                        ctl_level_2v5_o,
  input wire logic                        vco_high_range_o,
  input wire logic                        ref_rising_edge_o,
  input wire logic                        pll_bypass_o,
  input wire logic [ccw_pkg::FBDIV_W-1:0] fb_divide_code_o,
  input wire logic [ccw_pkg::NBANK-1:0]   bank_disabled_o,
  input wire logic                        disable_gated_o,
  input wire logic                        disable_stop_high_o
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // stop level follows the edge bit, inverted
  AST_STOP_LVL: assert property (
    $stable(ref_rising_edge_o) [*3] |-> disable_stop_high_o != ref_rising_edge_o)
    else $error("stop level not opposite of edge bit");
  // style pin alone forces the gated state
  AST_GATED_PIN: assert property (
    disable_style_pin_i [*8] |-> disable_gated_o)
    else $error("style pin high but outputs not gated");
  // every bank pin held high disables its bank
  AST_BANK_PIN: assert property (
    $stable(bank_sync_output_enable_i) [*8]
      |-> (bank_disabled_o & bank_sync_output_enable_i) == bank_sync_output_enable_i)
    else $error("bank pin high but bank enabled");
  // i2c use keeps the test data output released
  AST_SEL_TDO: assert property (
    !jtag_sel_i [*8] |-> !tdo_oe_o)
    else $error("test data output driven in i2c mode");
  // jtag use never acknowledges on the data line
  AST_SEL_SDA: assert property (
    jtag_sel_i [*8] |-> !sda_oe_o)
    else $error("data line pulled in jtag mode");
  // only one of the two shared outputs is ever driven
  AST_OE_ONE: assert property (
    !(tdo_oe_o && sda_oe_o))
    else $error("both shared outputs driven");
  // the data line is only ever pulled low
  AST_SDA_LOW: assert property (
    sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  // divide code, vco range and pll bypass hold while the active serial clock or data line stands still
  AST_HOLD: assert property (
    ((jtag_sel_i ? $stable(jtag_test_clock_i) : $stable(sda_i)) && $stable(jtag_sel_i)) [*8]
      |-> $stable(fb_divide_code_o) && $stable(vco_high_range_o) && $stable(pll_bypass_o))
    else $error("settings changed with no transaction end");

  // main scenarios
  COV_JTAG: cover property (jtag_sel_i && $changed(fb_divide_code_o));
  COV_I2C: cover property (!jtag_sel_i && $changed(fb_divide_code_o));
  COV_GATE: cover property ($rose(disable_gated_o));
endmodule

bind ccw_config_word ccw_config_word_props u_props (.*);

// ---- ccw_ctrl_model.sv ----
// partner: jtag and i2c programming controller on the shared pins
`timescale 1ns/1ps
module ccw_ctrl_model
  import ccw_pkg::*;
(
  // clock
  input wire logic clk_i,
  // pins toward the device
  output logic     sel_o,
  output logic     tck_o,
  output logic     tms_o,
  output logic     tdi_o,
  output logic     scl_o,
  output logic     sda_rel_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  input wire logic sda_line_i
);
  logic q; // last test data bit seen

  // idle levels, test clock stands low between frames
  initial begin
    sel_o = 1'b1;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
    q = 1'b0;
  end

  task w(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one 320 ns test clock period; output read just before the fall
  task tc(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    w(4);
    tck_o = 1'b1;
    w(4);
    q = tdo_oe_i ? tdo_i : ~q; // released line shows no stale value
    tck_o = 1'b0;
  endtask

  // load the config instruction, then shift a whole word
  task jtag_write(input logic [95:0] wd, output logic [95:0] rd);
    sel_o = 1'b1;
    w(8);
    repeat (5) tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b1, 1'b0);
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) tc(i == 3, IR_CONFIG[i]);
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b0, 1'b0);
    for (int i = 0; i < 96; i++) begin
      tc(i == 95, wd[i]);
      rd[i] = q;
    end
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
  endtask

  // one i2c bit; data moves while the clock is low
  task ib(input logic b, output logic r);
    w(1);
    sda_rel_o = b;
    w(4);
    scl_o = 1'b1;
    w(1);
    r = sda_line_i;
    w(2);
    scl_o = 1'b0;
  endtask

  // start, address, nb data bytes msb first, stop
  task i2c_write(input logic [6:0] a, input int nb, input logic [95:0] wd, output logic ack);
    logic r;
    logic [7:0] by;
    sel_o = 1'b0;
    w(8);
    sda_rel_o = 1'b0;
    w(4);
    scl_o = 1'b0;
    for (int k = -1; k < nb; k++) begin
      by = (k < 0) ? {a, 1'b0} : wd[95-8*k -: 8];
      for (int i = 7; i >= 0; i--) ib(by[i], r);
      ib(1'b1, r);
      if (k < 0) ack = ~r;
    end
    w(1);
    sda_rel_o = 1'b0;
    w(3);
    scl_o = 1'b1;
    w(4);
    sda_rel_o = 1'b1;
    w(8);
  endtask
endmodule

// ---- ccw_config_word_test.sv ----
// testbench: programs the configuration word over jtag and i2c and checks the settings
`timescale 1ns/1ps
module ccw_config_word_test;
  import ccw_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic jtag_sel_i, jtag_test_clock_i, tms_i, tdi_i, tdo_o, tdo_oe_o, scl_i, sda_o, sda_oe_o, sda_rel;
  logic [1:0] i2c_addr_i = 2'b10;
  logic disable_style_pin_i = 1'b0;
  logic [NBANK-1:0] bank_sync_output_enable_i = '0;
  logic ctl_level_2v5_o, vco_high_range_o, ref_rising_edge_o, pll_bypass_o, disable_gated_o, disable_stop_high_o;
  logic [FBDIV_W-1:0] fb_divide_code_o;
  logic [NBANK-1:0] bank_disabled_o;
  wire sda_i = sda_rel & (sda_oe_o ? sda_o : 1'b1); // pulled up
  wire [14:0] cfg = {ctl_level_2v5_o, vco_high_range_o, ref_rising_edge_o, pll_bypass_o,
                     fb_divide_code_o, bank_disabled_o, disable_gated_o, disable_stop_high_o};
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h4a798ea8;
  logic [31:0] r;
  logic [14:0] q_exp[$];
  event note_ev;
  logic [95:0] live = '0;
  logic [95:0] wd, rd;
  logic ack;
  logic [13:0] f;

  always #20 core_clk_i = ~core_clk_i;

  ccw_config_word dut (.*);
  ccw_ctrl_model u_ctrl (.clk_i(core_clk_i), .sel_o(jtag_sel_i), .tck_o(jtag_test_clock_i),
    .tms_o(tms_i), .tdi_o(tdi_i), .scl_o(scl_i), .sda_rel_o(sda_rel), .tdo_i(tdo_o),
    .tdo_oe_i(tdo_oe_o), .sda_line_i(sda_i));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // settings expected from word bits 61:48 and the pins
  function automatic logic [14:0] expv(input logic [13:0] v, input logic [4:0] p, input logic s);
    return {v[13], v[12], v[10], v[9], v[3:0], v[8:4] | p, v[11] | s, ~v[10]};
  endfunction

  task chk_cfg(input logic [14:0] e, input logic [14:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH settings exp %h got %h", e, g);
    end
  endtask
  task chk_ack(input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH address ack exp %b got %b", e, g);
    end
  endtask
  task chk_cap(input logic [95:0] e, input logic [95:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH captured word exp %h got %h", e, g);
    end
  endtask

  task tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // note the expected settings, then let them settle
  task note(input logic [4:0] p, input logic s);
    q_exp.push_back(expv(live[61:48], p, s));
    -> note_ev;
    repeat (16) @(negedge core_clk_i);
  endtask

  // watcher: compares the oldest note once the outputs have settled
  initial forever begin
    @(note_ev);
    repeat (12) @(negedge core_clk_i);
    chk_cfg(q_exp.pop_front(), cfg);
  end

  // watchdog: the run needs about 10600 cycles
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(negedge core_clk_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chk_cfg(15'h0001, cfg);
    // jtag words: all ones, all zeros, then random fields
    for (int n = 0; n < 7; n++) begin
      r = xs();
      f = (n == 0) ? 14'h3fff : (n == 1) ? 14'h0 : r[13:0];
      wd = {34'h0, f, r, r[31:16]};
      u_ctrl.jtag_write(wd, rd);
      chk_cap({live[95:48], 48'h0}, rd);
      live = wd;
      note(5'h0, 1'b0);
    end
    // pins or-ed with the word bits, last pass clears them
    for (int n = 0; n < 4; n++) begin
      r = (n == 3) ? 32'h0 : xs();
      bank_sync_output_enable_i = r[4:0];
      disable_style_pin_i = r[5];
      note(r[4:0], r[5]);
    end
    // i2c: wrong address, short write, then a full write
    r = xs();
    wd = {34'h0, r[13:0] ^ 14'h2aaa, r, r[31:16]};
    for (int n = 0; n < 3; n++) begin
      u_ctrl.i2c_write({I2C_BASE, n == 0 ? 2'b01 : 2'b10}, n == 1 ? 11 : 12, wd, ack);
      chk_ack(n != 0, ack);
      if (n == 2) live = wd;
      note(5'h0, 1'b0);
    end
    // back to jtag, reading the word that i2c left
    u_ctrl.jtag_write(96'h0, rd);
    chk_cap({live[95:48], 48'h0}, rd);
    live = '0;
    note(5'h0, 1'b0);
    tally_and_finish();
  end
endmodule
